// ### logic/spf_serial_port_unit.sv
// two synchronous serial ports with framing modes, word length, formats and shared compander
// assumes an APB master on pclk and external bit clocks far slower than pclk
//
// Functional notes
// R1 - normal framing: sync checked, data next falling edge
// R2 - sync ignored until current word finishes
// R3 - back-to-back sync comes in last bit
// R4 - alternate select: sync with first bit
// R5 - alternate: external sync checked first bit only
// R6 - internal alternate sync held whole word
// R7 - invert bits flip any frame signal
// R8 - word length is field plus one
// R9 - software never programs length zero or one
// R10 - per-port transmit and receive data registers
// R11 - one shared compander, port 0 wins
// R12 - transmit write arms, sends MSB first
// R13 - after first bit, transmit interrupt, register free
// R14 - complete word copied, receive interrupt raised
// R15 - format field: zero, sign, mu, A
// R16 - companded receive holds expanded eight LSBs
// R17 - companded transmit compressed, saturating large inputs
// R18 - compand in place, result one cycle later
// R19 - expansion completes before receive interrupt
// R20 - new write accepted during word in progress
// R21 - interrupt priority tx0, rx0, tx1, rx1
// R22 - law and format chosen per port
// R23 - unframed after first sync unless required
// R24 - internal transmit sync when fresh data loaded
// R25 - internal receive sync every divisor plus one
// R26 - framed, nothing pending: stop, pin idle
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "spf_cfg.svh"

module spf_serial_port_unit
	import spf_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] bit_clock,
	input wire logic [1:0] rx_data_pin,
	output logic [1:0] tx_data_pin,
	input wire logic [1:0] rx_frame_sync_in,
	output logic [1:0] rx_frame_sync_out,
	output logic [1:0] rx_frame_sync_oe_n,
	input wire logic [1:0] tx_frame_sync_in,
	output logic [1:0] tx_frame_sync_out,
	output logic [1:0] tx_frame_sync_oe_n,
	output logic [1:0] tx_irq,
	output logic [1:0] rx_irq,
	output logic irq_valid,
	output logic [1:0] irq_code
);

	// address decode shared by every per-port register
	function automatic logic spf_hit(input logic [7:0] addr, input logic port, input logic [7:0] off);
		return addr == (off + (port ? `SPF_PORT_STRIDE : 8'h00));
	endfunction

	// linear to eight-bit code, saturating at the law's range
	function automatic logic [7:0] spf_compress(input spf_word_t v, input logic alaw);
		logic neg;
		spf_word_t mag;
		logic [2:0] ex;
		logic [3:0] mt;
		neg = v[15];
		mag = neg ? (~v + 16'h0001) : v;
		ex = 3'h0;
		if (alaw) begin
			if (mag > `SPF_A_MAX) mag = `SPF_A_MAX;
			for (int i = 5; i < 12; i++) if (mag[i]) ex = 3'(i - 4);
			mt = (ex == 3'h0) ? mag[4:1] : 4'(mag >> ex);
			return {~neg, ex, mt} ^ `SPF_A_XOR;
		end
		if (mag > `SPF_MU_MAX) mag = `SPF_MU_MAX;
		mag = mag + `SPF_MU_BIAS;
		for (int i = 6; i < 13; i++) if (mag[i]) ex = 3'(i - 5);
		mt = 4'(mag >> ({1'b0, ex} + 4'h1)); // four-bit sum, top segment shifts by eight
		return ~{neg, ex, mt};
	endfunction

	// eight-bit code to right-justified signed linear value
	function automatic spf_word_t spf_expand(input logic [7:0] c, input logic alaw);
		logic [7:0] u;
		spf_word_t base;
		spf_word_t mag;
		logic neg;
		u = alaw ? (c ^ `SPF_A_XOR) : ~c;
		base = {11'h000, u[3:0], 1'b1};
		if (alaw) begin
			mag = (u[6:4] == 3'h0) ? base : ((base + `SPF_MU_BIAS - 16'h0001) << (u[6:4] - 3'h1));
			neg = ~u[7];
		end else begin
			mag = ((base + `SPF_MU_BIAS - 16'h0001) << u[6:4]) - `SPF_MU_BIAS; // bias removed as added
			neg = u[7];
		end
		return neg ? (~mag + 16'h0001) : mag;
	endfunction

	spf_word_t ctrl [2];
	spf_word_t tx_reg [2];
	spf_word_t rx_reg [2];
	spf_word_t div [2];
	logic cmp_req [2];
	logic exp_req [2];
	logic tx_active [2];
	logic tx_full [2];
	logic rx_active [2];
	logic tx_pulse [2];
	logic rx_pulse [2];
	logic [3:0] tx_cnt [2];

	// bus side: one wait state, so every access phase lasts two pclk cycles
	wire acc = psel & penable & pready;
	wire wr = acc & pwrite;
	wire rd_port = paddr[4];
	wire in_port = paddr[7:5] == 3'h0;
	wire is_status = paddr == `SPF_OFF_STATUS;
	wire [7:0] status = {exp_req[1], rx_active[1], tx_active[1], tx_full[1],
		exp_req[0], rx_active[0], tx_active[0], tx_full[0]};
	wire [7:0] rd_off = {4'h0, paddr[3:0]};
	wire spf_word_t rd_val = (rd_off == `SPF_OFF_CTRL) ? ctrl[rd_port] :
		(rd_off == `SPF_OFF_TX) ? tx_reg[rd_port] :
		(rd_off == `SPF_OFF_RX) ? rx_reg[rd_port] : div[rd_port];
	wire mapped = (in_port & (paddr[1:0] == 2'h0)) | is_status;
	wire [31:0] next_prdata = is_status ? {24'h000000, status} : in_port ? {16'h0000, rd_val} : 32'h00000000;

	// answer registered on the first access cycle, cleared after
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			prdata <= (psel & penable & ~pready & ~pwrite & mapped) ? next_prdata : 32'h00000000;
		end
	end

	// shared compander: one compression and one expansion per cycle
	wire cmp_src = cmp_req[0] ? 1'b0 : 1'b1; // R11
	wire exp_src = exp_req[0] ? 1'b0 : 1'b1; // R11
	wire [7:0] cmp_code = spf_compress(tx_reg[cmp_src], ctrl[cmp_src][`SPF_FMT_LSB]); // R17 R22
	wire spf_word_t cmp_res = {{8{cmp_code[7]}}, cmp_code};
	wire spf_word_t exp_res = spf_expand(rx_reg[exp_src][7:0], ctrl[exp_src][`SPF_FMT_LSB]); // R16 R22

	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_port
			logic [2:0] sck;
			logic [1:0] tfs_s;
			logic [1:0] rfs_s;
			logic [1:0] dr_s;
			logic tx_go;
			logic tx_started;
			logic tx_pin;
			logic [15:0] tx_sh;
			logic rx_go;
			logic rx_started;
			logic [3:0] rx_cnt;
			logic [15:0] rx_sh;
			logic [15:0] div_pos;
			logic exp_irq;

			// control fields of this port
			wire [3:0] wl = ctrl[p][`SPF_WL_MSB:`SPF_WL_LSB]; // R8
			wire [4:0] len = {1'b0, wl} + 5'h01; // R8
			wire [3:0] pad = `SPF_WORD_MSB - wl;
			wire spf_fmt_t fmt = spf_fmt_t'(ctrl[p][`SPF_FMT_MSB:`SPF_FMT_LSB]);
			wire cmpd = fmt[1]; // R15
			wire t_alt = ctrl[p][`SPF_TX_ALT]; // R4
			wire r_alt = ctrl[p][`SPF_RX_ALT]; // R4
			wire t_int = ctrl[p][`SPF_TX_INT];
			wire r_int = ctrl[p][`SPF_RX_INT];
			wire fall = sck[2] & ~sck[1];
			wire wr_ctrl = wr & spf_hit(paddr, p[0], `SPF_OFF_CTRL);
			wire wr_tx = wr & spf_hit(paddr, p[0], `SPF_OFF_TX); // R10
			wire wr_rx = wr & spf_hit(paddr, p[0], `SPF_OFF_RX); // R10
			wire wr_div = wr & spf_hit(paddr, p[0], `SPF_OFF_DIV);
			wire cmp_gnt = cmp_req[p] & (cmp_src == p[0]); // R11
			wire exp_gnt = exp_req[p] & (exp_src == p[0]); // R11

			// transmit framing decisions
			wire tx_ready = tx_full[p] & ~cmp_req[p];
			wire tx_seen = t_int ? tx_ready : (tfs_s[1] ^ ctrl[p][`SPF_TX_INV]); // R7 R24
			wire tx_ok = tx_ready & (tx_seen | (~ctrl[p][`SPF_TX_FREQ] & tx_started)); // R23 R26
			wire tx_alt_load = t_alt & (~tx_active[p] | (tx_cnt[p] == 4'h0)) & tx_ok; // R4 R5
			wire tx_load = fall & ((tx_go & ~cmp_req[p]) | tx_alt_load); // R1 R12
			wire tx_norm_dec = fall & ~t_alt & ~tx_go & (~tx_active[p] | (tx_cnt[p] == 4'h1)) & tx_ok; // R2 R3
			wire spf_word_t tx_aligned = tx_reg[p] << pad;
			wire tx_fs_lvl = t_alt ? tx_active[p] : tx_go; // R6 R24

			// receive framing decisions
			wire r_int_seen = r_alt ? (div_pos < {11'h000, len}) : (div_pos == 16'h0000); // R25 R6
			wire rx_seen = r_int ? r_int_seen : (rfs_s[1] ^ ctrl[p][`SPF_RX_INV]); // R7
			wire rx_ok = rx_seen | (~ctrl[p][`SPF_RX_FREQ] & rx_started); // R23
			wire rx_start = fall & (rx_go | (r_alt & ~rx_active[p] & rx_ok)); // R1 R5
			wire rx_norm_dec = fall & ~r_alt & ~rx_go & (~rx_active[p] | (rx_cnt == 4'h1)) & rx_ok; // R2 R3
			wire rx_done = fall & rx_active[p] & (rx_cnt == 4'h1) & ~rx_start; // R14
			wire spf_word_t rx_word = {rx_sh[14:0], dr_s[1]};
			wire spf_word_t rx_fmt = (fmt == SPF_FMT_ZERO) ? (rx_word & (16'hFFFF >> pad)) :
				(fmt == SPF_FMT_SIGN) ? 16'($signed(rx_word << pad) >>> pad) :
				{8'h00, rx_word[7:0]}; // R15 R16

			// pin synchronisers; the first stage feeds only the second
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sck <= 3'h0;
					tfs_s <= 2'h0;
					rfs_s <= 2'h0;
					dr_s <= 2'h0;
				end else begin
					sck <= {sck[1:0], bit_clock[p]};
					tfs_s <= {tfs_s[0], tx_frame_sync_in[p]};
					rfs_s <= {rfs_s[0], rx_frame_sync_in[p]};
					dr_s <= {dr_s[0], rx_data_pin[p]};
				end
			end

			// software registers; a software write to tx_reg takes precedence over the compression write-back
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ctrl[p] <= `SPF_CTRL_RST; // R7 R23
					div[p] <= `SPF_DIV_RST;
					tx_reg[p] <= 16'h0000;
					cmp_req[p] <= 1'b0;
				end else begin
					if (wr_ctrl) ctrl[p] <= pwdata[15:0];
					if (wr_div) div[p] <= pwdata[15:0];
					if (wr_tx) tx_reg[p] <= pwdata[15:0]; // R20
					else if (cmp_gnt) tx_reg[p] <= cmp_res; // R18
					cmp_req[p] <= wr_tx ? cmpd : (cmp_gnt ? 1'b0 : cmp_req[p]); // R17 R18
				end
			end

			// transmit shifter, MSB first; write during a word only refills the holding register
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					tx_active[p] <= 1'b0;
					tx_full[p] <= 1'b0;
					tx_go <= 1'b0;
					tx_started <= 1'b0;
					tx_pin <= 1'b0;
					tx_sh <= 16'h0000;
					tx_cnt[p] <= 4'h0;
					tx_pulse[p] <= 1'b0;
				end else begin
					tx_full[p] <= wr_tx ? 1'b1 : (tx_load ? 1'b0 : tx_full[p]); // R12 R20
					tx_go <= tx_load ? 1'b0 : (tx_norm_dec ? 1'b1 : tx_go); // R1 R24
					tx_pulse[p] <= fall & tx_active[p] & (tx_cnt[p] == wl) & ~tx_load; // R13
					if (tx_load) begin
						tx_sh <= tx_aligned; // R12
						tx_pin <= tx_aligned[15];
						tx_cnt[p] <= wl; // R8
						tx_active[p] <= 1'b1;
						tx_started <= 1'b1; // R23
					end else if (fall & tx_active[p] & (tx_cnt[p] != 4'h0)) begin
						tx_sh <= tx_sh << 1;
						tx_pin <= tx_sh[14];
						tx_cnt[p] <= tx_cnt[p] - 4'h1;
					end else if (fall & tx_active[p]) begin
						tx_active[p] <= 1'b0; // R26
						tx_pin <= 1'b0;
					end
				end
			end

			// receive shifter and receive-register write-back
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					rx_active[p] <= 1'b0;
					rx_go <= 1'b0;
					rx_started <= 1'b0;
					rx_cnt <= 4'h0;
					rx_sh <= 16'h0000;
					rx_reg[p] <= 16'h0000;
					exp_req[p] <= 1'b0;
					exp_irq <= 1'b0;
					rx_pulse[p] <= 1'b0;
				end else begin
					rx_go <= rx_start ? 1'b0 : (rx_norm_dec ? 1'b1 : rx_go); // R1
					if (rx_start) begin
						rx_sh <= {15'h0000, dr_s[1]};
						rx_cnt <= wl; // R8
						rx_active[p] <= 1'b1;
						rx_started <= 1'b1;
					end else if (fall & rx_active[p]) begin
						rx_sh <= rx_word;
						rx_cnt <= rx_cnt - 4'h1;
						rx_active[p] <= rx_cnt != 4'h1;
					end
					if (rx_done) rx_reg[p] <= rx_fmt; // R14
					else if (exp_gnt) rx_reg[p] <= exp_res; // R16 R18
					else if (wr_rx) rx_reg[p] <= pwdata[15:0];
					exp_req[p] <= ((rx_done | wr_rx) & cmpd) | (exp_req[p] & ~exp_gnt); // R18
					exp_irq <= (rx_done & cmpd) | (exp_irq & ~exp_gnt);
					rx_pulse[p] <= (rx_done & ~cmpd) | (exp_gnt & exp_irq); // R14 R19
				end
			end

			// internal receive frame period and frame pin drivers
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					div_pos <= 16'h0000;
					tx_frame_sync_out[p] <= 1'b0;
					rx_frame_sync_out[p] <= 1'b0;
					tx_frame_sync_oe_n[p] <= 1'b1;
					rx_frame_sync_oe_n[p] <= 1'b1;
				end else begin
					if (fall) div_pos <= (div_pos >= div[p]) ? 16'h0000 : div_pos + 16'h0001; // R25
					tx_frame_sync_out[p] <= tx_fs_lvl ^ ctrl[p][`SPF_TX_INV]; // R7
					rx_frame_sync_out[p] <= r_int_seen ^ ctrl[p][`SPF_RX_INV]; // R7
					tx_frame_sync_oe_n[p] <= ~t_int;
					rx_frame_sync_oe_n[p] <= ~r_int;
				end
			end

			assign tx_data_pin[p] = tx_pin;
			assign tx_irq[p] = tx_pulse[p];
			assign rx_irq[p] = rx_pulse[p];
		end
	endgenerate

	// fixed-priority encoding of coincident serial events
	wire any_evt = tx_pulse[0] | rx_pulse[0] | tx_pulse[1] | rx_pulse[1];
	wire [1:0] next_code = tx_pulse[0] ? 2'h0 : rx_pulse[0] ? 2'h1 : tx_pulse[1] ? 2'h2 : 2'h3; // R21
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_valid <= 1'b0;
			irq_code <= 2'h0;
		end else begin
			irq_valid <= any_evt;
			irq_code <= any_evt ? next_code : 2'h0;
		end
	end

	property p_prio_tx0;
		@(posedge pclk) disable iff (!presetn) tx_pulse[0] |=> irq_valid && irq_code == 2'h0;
	endproperty
	a_prio_tx0: assert property (p_prio_tx0) else $error("tx0 event not top priority"); // R21

	property p_prio_rx0;
		@(posedge pclk) disable iff (!presetn) (rx_pulse[0] && !tx_pulse[0]) |=> irq_code == 2'h1;
	endproperty
	a_prio_rx0: assert property (p_prio_rx0) else $error("rx0 event not second priority"); // R21

	property p_share;
		@(posedge pclk) disable iff (!presetn) (cmp_req[0] && cmp_req[1] && !g_port[0].wr_tx) |=> !cmp_req[0] && cmp_req[1];
	endproperty
	a_share: assert property (p_share) else $error("port 1 compressed ahead of port 0"); // R11

	property p_inplace;
		@(posedge pclk) disable iff (!presetn) (g_port[0].wr_tx && g_port[0].cmpd) |=> cmp_req[0] ##1 !cmp_req[0];
	endproperty
	a_inplace: assert property (p_inplace) else $error("compression not done one cycle after write"); // R18

	property p_exp_first;
		@(posedge pclk) disable iff (!presetn) (rx_pulse[0] && g_port[0].cmpd) |-> !exp_req[0] && $past(exp_req[0]);
	endproperty
	a_exp_first: assert property (p_exp_first) else $error("receive event before expansion"); // R19

	property p_len;
		@(posedge pclk) disable iff (!presetn) g_port[0].tx_load |=> tx_active[0] && tx_cnt[0] == $past(g_port[0].wl);
	endproperty
	a_len: assert property (p_len) else $error("word length count wrong"); // R8

	property p_idle_pin;
		@(posedge pclk) disable iff (!presetn) !tx_active[0] |-> !tx_data_pin[0];
	endproperty
	a_idle_pin: assert property (p_idle_pin) else $error("data pin not idle between words"); // R26

	property p_tx_evt;
		@(posedge pclk) disable iff (!presetn) tx_pulse[0] |-> tx_active[0] && $past(tx_cnt[0]) == g_port[0].wl;
	endproperty
	a_tx_evt: assert property (p_tx_evt) else $error("transmit event not after first bit"); // R13

	property p_rx_plain;
		@(posedge pclk) disable iff (!presetn) (g_port[0].rx_done && !g_port[0].cmpd) |=> rx_pulse[0];
	endproperty
	a_rx_plain: assert property (p_rx_plain) else $error("receive event missing after word"); // R14

endmodule

// ### logic/spf_cfg.svh
// register offsets, control field positions, reset values and companding limits
// assumes inclusion by bare name from the serial port unit and its package users
`ifndef SPF_CFG_SVH
`define SPF_CFG_SVH

`define SPF_OFF_CTRL 8'h00
`define SPF_OFF_TX 8'h04
`define SPF_OFF_RX 8'h08
`define SPF_OFF_DIV 8'h0C
`define SPF_PORT_STRIDE 8'h10
`define SPF_OFF_STATUS 8'h20

`define SPF_WL_LSB 0
`define SPF_WL_MSB 3
`define SPF_FMT_LSB 4
`define SPF_FMT_MSB 5
`define SPF_RX_FREQ 6
`define SPF_TX_FREQ 7
`define SPF_RX_ALT 8
`define SPF_TX_ALT 9
`define SPF_RX_INV 10
`define SPF_TX_INV 11
`define SPF_RX_INT 12
`define SPF_TX_INT 13

`define SPF_CTRL_RST 16'h000F
`define SPF_DIV_RST 16'h000F
`define SPF_WORD_MSB 4'hF

`define SPF_MU_MAX 16'h1FDE
`define SPF_A_MAX 16'h0FFF
`define SPF_MU_BIAS 16'h0021
`define SPF_A_XOR 8'h55

`endif

// ### logic/spf_pkg.sv
// types shared by the serial port unit
// assumes spf_cfg.svh carries every numeric constant
package spf_pkg;
	typedef enum logic [1:0] {
		SPF_FMT_ZERO = 2'b00,
		SPF_FMT_SIGN = 2'b01,
		SPF_FMT_MU = 2'b10,
		SPF_FMT_A = 2'b11
	} spf_fmt_t;
	typedef logic [15:0] spf_word_t;
endpackage

// ### bench/spf_codec_model.sv
// far-side model of one serial link: bit clock, frame sync, receive data, transmit capture
// assumes the port acts on bit clock falls; the clock stands still high between frames
`timescale 1ns/1ps

module spf_codec_model (
	output logic bit_clock,
	output logic frame_sync,
	output logic rx_data,
	input wire logic tx_data
);
	logic [15:0] captured;

	// idle levels before the first frame
	initial begin
		bit_clock = 1'b1;
		frame_sync = 1'b0;
		rx_data = 1'b0;
		captured = 16'h0000;
	end

	// one word; normal sync leads data by a cycle, alternate sync sits on the first bit
	task automatic frame(input logic alt, input logic inv, input int len, input logic [15:0] d);
		int s;
		int b;
		s = alt ? 0 : 1;
		captured = 16'h0000;
		// odd offset keeps link edges away from pclk edges
		#37;
		for (int c = 0; c <= len + s; c++) begin
			bit_clock = 1'b1;
			b = c - s;
			// a second pulse mid-word must be ignored
			frame_sync = ((c == 0) || (c == 2 && len > 3)) ^ inv;
			// outside the word the line toggles, never a stale bit
			rx_data = (b >= 0 && b < len) ? d[len - 1 - b] : ~rx_data;
			#400;
			bit_clock = 1'b0;
			if (b >= 1 && b <= len)
				captured = {captured[14:0], tx_data};
			#400;
		end
		bit_clock = 1'b1;
	endtask
endmodule

// ### bench/spf_serial_port_unit_tb.sv
// self-checking bench for the two-port serial unit, registers over APB
// assumes one spf_codec_model per port and the map of spf_cfg.svh
`timescale 1ns/1ps
`include "spf_cfg.svh"

module spf_serial_port_unit_tb
	import spf_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_valid;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	// one model drives each bit, so these are nets
	wire [1:0] bit_clock, rx_data_pin, fs;
	logic [1:0] tx_data_pin, tx_irq, rx_irq, irq_code, last_code;
	logic [1:0] rx_fs_out, rx_fs_oe_n, tx_fs_out, tx_fs_oe_n, rx_fs_w, tx_fs_w;
	int n_mismatch, check_count;
	int tx_n[2];
	int rx_n[2];

	// frame pins resolve between device and model drivers
	assign rx_fs_w = (rx_fs_oe_n & fs) | (~rx_fs_oe_n & rx_fs_out);
	assign tx_fs_w = (tx_fs_oe_n & fs) | (~tx_fs_oe_n & tx_fs_out);

	spf_serial_port_unit dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bit_clock(bit_clock), .rx_data_pin(rx_data_pin), .tx_data_pin(tx_data_pin),
		.rx_frame_sync_in(rx_fs_w), .rx_frame_sync_out(rx_fs_out), .rx_frame_sync_oe_n(rx_fs_oe_n),
		.tx_frame_sync_in(tx_fs_w), .tx_frame_sync_out(tx_fs_out), .tx_frame_sync_oe_n(tx_fs_oe_n),
		.tx_irq(tx_irq), .rx_irq(rx_irq), .irq_valid(irq_valid), .irq_code(irq_code)
	);

	spf_codec_model far0 (.bit_clock(bit_clock[0]), .frame_sync(fs[0]), .rx_data(rx_data_pin[0]),
		.tx_data(tx_data_pin[0]));
	spf_codec_model far1 (.bit_clock(bit_clock[1]), .frame_sync(fs[1]), .rx_data(rx_data_pin[1]),
		.tx_data(tx_data_pin[1]));

	// 10 MHz system clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// count interrupt pulses, keep the last reported source
	always @(posedge pclk) begin
		for (int i = 0; i < 2; i++) begin
			if (tx_irq[i] === 1'b1)
				tx_n[i]++;
			if (rx_irq[i] === 1'b1)
				rx_n[i]++;
		end
		if (irq_valid === 1'b1)
			last_code <= irq_code;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// one APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			n_mismatch++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h00000000, r, e);
		check(r, exp);
	endtask

	// reset values, refused address, idle pins
	task automatic s_regs();
		logic [31:0] r;
		logic e;
		rd(`SPF_OFF_CTRL, {16'h0000, `SPF_CTRL_RST});
		rd(`SPF_PORT_STRIDE + `SPF_OFF_DIV, {16'h0000, `SPF_DIV_RST});
		rd(`SPF_OFF_STATUS, 32'h00000000);
		apb(1'b0, 8'h30, 32'h00000000, r, e);
		check({31'h0, e}, 32'h00000001);
		check({30'h0, tx_data_pin}, 32'h00000000);
	endtask

	// in-place compression and expansion, a different law on each port
	task automatic s_compand();
		wr(`SPF_OFF_CTRL, 32'h0000002F);
		wr(`SPF_PORT_STRIDE + `SPF_OFF_CTRL, 32'h0000003F);
		wr(`SPF_OFF_TX, 32'h00000000);
		rd(`SPF_OFF_TX, 32'h0000FFFF);
		wr(`SPF_PORT_STRIDE + `SPF_OFF_TX, 32'h00000000);
		rd(`SPF_PORT_STRIDE + `SPF_OFF_TX, 32'h0000FFD5);
		wr(`SPF_OFF_TX, 32'h00007FFF);
		rd(`SPF_OFF_TX, 32'h0000FF80);
		wr(`SPF_OFF_TX, 32'h00001000);
		rd(`SPF_OFF_TX, 32'h0000FF8F);
		wr(`SPF_PORT_STRIDE + `SPF_OFF_TX, 32'h00007FFF);
		rd(`SPF_PORT_STRIDE + `SPF_OFF_TX, 32'h0000FFAA);
		wr(`SPF_OFF_RX, 32'h00000080);
		rd(`SPF_OFF_RX, 32'h00001F5F);
	endtask

	// one framed word each way; unless itx is set, the next tx word is written while this one is sent
	task automatic s_frame(input int p, input logic alt, input logic inv, input int len, input spf_fmt_t fmt,
		input logic [15:0] txd, input logic [15:0] rxd, input logic itx);
		logic [7:0] base;
		logic [15:0] m;
		logic [15:0] cap;
		int t0;
		int r0;
		int n_fs;
		logic done;
		base = (p == 1) ? `SPF_PORT_STRIDE : 8'h00;
		m = 16'((32'h1 << len) - 1);
		t0 = tx_n[p];
		r0 = rx_n[p];
		n_fs = 0;
		done = 1'b0;
		wr(base, {16'h0, 2'b00, itx, 1'b0, inv, inv, alt, alt, 2'b11, fmt, 4'(len - 1)});
		wr(base + `SPF_OFF_TX, {16'h0000, txd});
		fork
			begin
				if (p == 0)
					far0.frame(alt, inv, len, rxd);
				else
					far1.frame(alt, inv, len, rxd);
				done = 1'b1;
			end
			begin
				for (int i = 0; i < 300 && tx_n[p] == t0; i++)
					@(posedge pclk);
				// internally framed word must stop cleanly, so nothing new is queued
				if (!itx)
					wr(base + `SPF_OFF_TX, {16'h0000, ~txd});
			end
			// asserted internal sync counted in pclk cycles until the link clock stops
			while (!done) begin
				@(posedge pclk);
				if (tx_fs_out[p] === ~inv)
					n_fs++;
			end
		join
		for (int i = 0; i < 50 && rx_n[p] == r0; i++)
			@(posedge pclk);
		cap = (p == 0) ? far0.captured : far1.captured;
		check({16'h0000, cap}, {16'h0000, txd & m});
		check(tx_n[p] - t0, 32'h00000001);
		check(rx_n[p] - r0, 32'h00000001);
		check({30'h0, last_code}, 2 * p + 1);
		// eight pclk per bit cycle of the 800 ns link clock
		if (itx)
			check(n_fs, len * 8);
		check({30'h0, tx_fs_oe_n[p], rx_fs_oe_n[p]}, {30'h0, ~itx, 1'b1});
		rd(base + `SPF_OFF_RX, {16'h0000, (rxd & m) | ((fmt == SPF_FMT_SIGN && rxd[len - 1]) ? ~m : 16'h0000)});
	endtask

	// main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		last_code = 2'b00;
		n_mismatch = 0;
		check_count = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		s_regs();
		s_compand();
		s_frame(0, 1'b0, 1'b0, 4, SPF_FMT_ZERO, 16'h000B, 16'h000D, 1'b0);
		s_frame(0, 1'b1, 1'b0, 16, SPF_FMT_SIGN, 16'hA5C3, 16'h9E71, 1'b0);
		s_frame(1, 1'b0, 1'b1, 3, SPF_FMT_SIGN, 16'h0005, 16'h0006, 1'b0);
		s_frame(1, 1'b1, 1'b1, 16, SPF_FMT_ZERO, 16'h3C96, 16'hC3A5, 1'b1);
		tally_and_finish();
	end

	// watchdog far beyond the expected run of about 50 us
	initial begin
		#2000000;
		n_mismatch++;
		tally_and_finish();
	end
endmodule
